// ==== bench/pcm_codec_model.sv ====
`timescale 1ns/1ps
// far-side pcm master plus an echoing codec
module pcm_codec_model
(
   input wire logic run,
   input wire logic long_fmt,
   input wire logic [7:0] nbits,
   input wire logic dout,
   input wire logic dout_oe,
   output logic clk,
   output logic sync,
   output logic din
);
   logic last = 1'b0;
   // clock only within frames, off phase from hclk
   initial
   begin
      clk = 1'b0;
      sync = 1'b0;
      forever
      begin
         wait (run);
         #1.3;
         for (int b = 0; b < nbits; b++)
         begin
            #80 clk = 1'b1;
            sync = long_fmt ? (b < 3) : (b == nbits - 1);
            #80 clk = 1'b0;
         end
         if (!run)
            sync = 1'b0;
      end
   end
   // echo the line; a released line shows the inverse of its last bit
   always @(dout or dout_oe)
      if (dout_oe)
         last = dout;
   assign din = dout_oe ? dout : ~last;
endmodule

// ==== bench/pcm_voice_assertions.sv ====
`timescale 1ns/1ps
module pcm_voice_checker
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic pcm_clk_o,
   input wire logic pcm_clk_oe,
   input wire logic pcm_sync_o,
   input wire logic pcm_sync_oe,
   input wire logic pcm_dout,
   input wire logic pcm_dout_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic clk_d;
   logic [2:0] rises_reg;
   logic [2:0] rises_next;
   // bit clock rises seen while sync stands high
   assign rises_next = !pcm_sync_o ? 3'h0 :
      rises_reg + {2'h0, pcm_clk_o && !clk_d};
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_d <= 1'b0;
         rises_reg <= 3'h0;
      end
      else
      begin
         clk_d <= pcm_clk_o;
         rises_reg <= rises_next;
      end
   end
   sequence taken_s;
      hsel && hready && htrans[1];
   endsequence
   sequence wait_s;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_bus_wait: assert property (taken_s |=> wait_s)
      else $error("bus wait state wrong");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   chk_pins_paired: assert property (pcm_clk_oe == pcm_sync_oe)
      else $error("clock and sync drive differ");
   chk_dout_steady: assert property (pcm_clk_oe && $past(pcm_clk_oe)
      && !pcm_clk_o |-> $stable(pcm_dout))
      else $error("data moved while bit clock low");
   chk_oe_release: assert property (pcm_clk_oe && $fell(pcm_dout_oe)
      |-> !pcm_clk_o)
      else $error("data released outside low phase");
   chk_oe_launch: assert property (pcm_clk_oe && $rose(pcm_dout_oe)
      |-> pcm_clk_o)
      else $error("data driven outside high phase");
   chk_sync_rise: assert property (pcm_sync_oe && $rose(pcm_sync_o)
      |-> pcm_clk_o)
      else $error("sync not started on rising edge");
   chk_sync_fall: assert property (pcm_sync_oe && $fell(pcm_sync_o)
      |-> pcm_clk_o)
      else $error("sync not ended on rising edge");
   chk_sync_length: assert property (rises_reg <= 3'h3)
      else $error("sync longer than three bits");
endmodule

bind pcm_voice_slot_interface pcm_voice_checker pcm_voice_checker_inst (
   .hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hresp,
   .pcm_clk_o, .pcm_clk_oe, .pcm_sync_o, .pcm_sync_oe, .pcm_dout,
   .pcm_dout_oe);

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb
   import pcm_voice_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic prun = 1'b0, plong = 1'b0, cw_d = 1'b0, sw_d = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] rc = 8'h0;
   logic hreadyout, hresp, pcm_clk_o, pcm_clk_oe, pcm_sync_o, pcm_sync_oe;
   logic pcm_dout, pcm_dout_oe, din, pclk, psync;
   int err_count = 0, n_tests = 0;
   wire clk_w = pcm_clk_oe ? pcm_clk_o : pclk;
   wire sync_w = pcm_sync_oe ? pcm_sync_o : psync;

   always #2 hclk = ~hclk;

   pcm_voice_slot_interface pcm_voice_slot_interface_inst (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .pcm_clk_i(clk_w), .pcm_clk_o,
      .pcm_clk_oe, .pcm_sync_i(sync_w), .pcm_sync_o, .pcm_sync_oe,
      .pcm_din(din), .pcm_dout, .pcm_dout_oe);
   pcm_codec_model pcm_codec_model_inst (.run(prun), .long_fmt(plong),
      .nbits(8'h40), .dout(pcm_dout), .dout_oe(pcm_dout_oe), .clk(pclk),
      .sync(psync), .din);

   // bit clock rises since frame sync dropped
   always @(posedge hclk)
   begin
      cw_d <= clk_w;
      sw_d <= sync_w;
      rc <= (sw_d && !sync_w) ? 8'h0 : rc + {7'h0, clk_w && !cw_d};
   end

   task test_done;
      $display("tests %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // a used-up wait counts against the run and stops it
   task guard(input int n, input int lim);
      if (n >= lim)
      begin
         err_count++;
         test_done;
      end
   endtask

   // one single transfer, waiting on hready for each phase
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
      guard(n, 99);
      rd = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   // pop the receive queue dry, keeping the newest word
   task pop_all(output logic [31:0] last, output int cnt);
      logic [31:0] rd;
      last = 32'h0;
      cnt = 0;
      do
      begin
         ahb(1'b0, ADDR_RX, 32'h0, rd);
         if (rd[RX_VALID])
         begin
            last = rd;
            cnt++;
         end
      end while (rd[RX_VALID] && cnt < 6);
   endtask

   task wait_oe(input logic v);
      int n;
      n = 0;
      while (pcm_dout_oe !== v && n < 9999) begin @(posedge hclk); n++; end
      guard(n, 9999);
   endtask

   // second owned slot off the line, bits taken at falling edges;
   // the first may be cut short by a map write or come before any sync
   task get_word(output logic [15:0] w, output logic [7:0] r);
      int i, n;
      i = 0;
      n = 0;
      wait_oe(1'b0);
      wait_oe(1'b1);
      wait_oe(1'b0);
      wait_oe(1'b1);
      r = rc;
      w = 16'h0;
      while (i < 16 && n < 999)
      begin
         @(posedge hclk);
         n++;
         if (cw_d && !clk_w)
         begin
            w = {w[14:0], pcm_dout};
            i++;
         end
      end
      guard(n, 999);
   endtask

   function automatic logic [15:0] exp_word(logic [12:0] s, logic [1:0] p,
      logic [1:0] f, logic [15:0] pat, logic lsbf);
      logic [15:0] m, fv, w, r;
      m = SAMPLE_MASK << p;
      fv = (f == FILL_ZERO) ? 16'h0 : (f == FILL_ONE) ? 16'hFFFF :
         (f == FILL_SIGN) ? {16{s[12]}} : pat;
      w = (({3'h0, s} << p) & m) | (fv & ~m);
      r = {<<{w}};
      return lsbf ? r : w;
   endfunction

   initial
   begin
      logic [31:0] rd;
      logic [15:0] w, pat;
      logic [12:0] s;
      logic [7:0] r;
      logic [5:0] d;
      logic [1:0] pos, fill, slot, ch;
      logic lsbf, mst, lng;
      int cnt;
      logic [7:0] ra [5];
      logic [31:0] rv [5];
      ra = '{ADDR_CTRL, ADDR_DIV, ADDR_MAP, ADDR_FMT, 8'h40};
      rv = '{{26'h0, CTRL_RST}, {24'h0, DIV_RST},
         {17'h0, MAP_RST}, {27'h0, FMT_RST}, 32'h0};
      void'($urandom(32'hE212));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         ahb(1'b0, ra[k], 32'h0, rd);
         check(rd, rv[k]);
      end
      $display("test reset values done");
      // half period of 4 cycles leaves room for the 2-flop input delay
      wr(ADDR_DIV, 32'h3);
      // modes, fills and channels in turn, slot at random
      for (int i = 0; i < 8; i++)
      begin
         mst = i[0];
         lng = i[1];
         fill = i[2:1];
         ch = 2'(i % 3);
         slot = 2'($urandom);
         pos = (i == 0) ? 2'h3 : 2'($urandom);
         lsbf = (i == 0) ? 1'b0 : 1'($urandom);
         s = 13'($urandom);
         pat = 16'($urandom);
         wr(ADDR_CTRL, 32'h0);
         wr(ADDR_MAP, 32'h0);
         prun <= !mst;
         plong <= lng;
         wr(ADDR_FMT, {pat, 11'h0, fill, lsbf, pos});
         wr(ADDR_TX0 + {4'h0, ch, 2'h0}, {19'h0, s});
         wr(ADDR_CTRL, {26'h0, 3'h2, lng, mst, 1'b1});
         pop_all(rd, cnt);
         wr(ADDR_MAP, ({28'h0, slot} << (4 * ch)) | (32'h1000 << ch));
         get_word(w, r);
         check({16'h0, w}, {16'h0, exp_word(s, pos, fill, pat, lsbf)});
         d = 6'(r + (lng ? 8'h3 : 8'h0) - {2'h0, slot, 4'h0});
         check({31'h0, d <= 6'h2 || d >= 6'h3E}, 32'h1);
         repeat (4) @(posedge hclk);
         pop_all(rd, cnt);
         check(rd & 32'h80031FFF, {1'b1, 13'h0, ch, 3'h0, s});
         $display("test frame %0d done", i);
      end
      // leave the queue unread while frames keep arriving
      repeat (6) get_word(w, r);
      ahb(1'b0, ADDR_STAT, 32'h0, rd);
      check(rd & 32'h6, 32'h6);
      wr(ADDR_MAP, 32'h0);
      repeat (300) @(posedge hclk);
      pop_all(rd, cnt);
      check(cnt, FIFO_DEPTH);
      wr(ADDR_STAT, 32'h2);
      ahb(1'b0, ADDR_STAT, 32'h0, rd);
      check(rd & 32'h6, 32'h0);
      $display("test queue full done");
      test_done;
   end
endmodule

// ==== hdl/pcm_voice_pkg.sv ====
package pcm_voice_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DIV = 8'h04;
   localparam logic [7:0] ADDR_MAP = 8'h08;
   localparam logic [7:0] ADDR_FMT = 8'h0C;
   localparam logic [7:0] ADDR_TX0 = 8'h10;
   localparam logic [7:0] ADDR_TX1 = 8'h14;
   localparam logic [7:0] ADDR_TX2 = 8'h18;
   localparam logic [7:0] ADDR_RX = 8'h1C;
   localparam logic [7:0] ADDR_STAT = 8'h20;

   // control fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_MASTER = 1;
   localparam int CTRL_LONG = 2;
   localparam int CTRL_RATE_LSB = 3;
   localparam int CTRL_W = 6;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [2:0] RATE_MAX = 3'h4;

   // bit clock half period less one, in hclk cycles (1024 kHz at 250 MHz)
   localparam logic [7:0] DIV_RST = 8'h79;

   // slot map: 4-bit slot per channel, enables above
   localparam int NUM_CH = 3;
   localparam int MAP_EN_LSB = 12;
   localparam logic [14:0] MAP_RST = 15'h0000;

   // format fields
   localparam int FMT_POS_LSB = 0;
   localparam int FMT_LSBF = 2;
   localparam int FMT_FILL_LSB = 3;
   localparam int FMT_PAT_LSB = 16;
   localparam logic [4:0] FMT_RST = 5'h03;
   localparam logic [15:0] PAT_RST = 16'h0000;
   localparam logic [1:0] FILL_ZERO = 2'h0;
   localparam logic [1:0] FILL_ONE = 2'h1;
   localparam logic [1:0] FILL_SIGN = 2'h2;

   // sample and slot geometry
   localparam int SAMPLE_W = 13;
   localparam int WORD_W = 16;
   localparam logic [15:0] SAMPLE_MASK = 16'h1FFF;
   localparam logic [3:0] BIT_LAST = 4'hF;
   localparam logic [7:0] LONG_SYNC_LAST = 8'h02;
   localparam logic [7:0] BIT_IDLE = 8'hFF;

   // receive word and status fields
   localparam int RX_W = 15;
   localparam int RX_CH_LSB = 16;
   localparam int RX_VALID = 31;
   localparam int FIFO_DEPTH = 4;
   localparam int STAT_LOCK = 0;
   localparam int STAT_OVR = 1;
   localparam int STAT_RXV = 2;
   localparam int STAT_SLOT_LSB = 4;

   localparam logic RESP_OKAY = 1'b0;

   typedef enum logic [1:0] {ST_OFF, ST_HUNT, ST_RUN} link_state_t;

endpackage

// ==== hdl/pcm_voice_slot_interface.sv ====
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module pcm_voice_slot_interface
   import pcm_voice_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic pcm_clk_i,
   output logic pcm_clk_o,
   output logic pcm_clk_oe,
   input wire logic pcm_sync_i,
   output logic pcm_sync_o,
   output logic pcm_sync_oe,
   input wire logic pcm_din,
   output logic pcm_dout,
   output logic pcm_dout_oe
);

   // bus data phase bookkeeping
   logic pend_reg;
   logic pend_write_reg;
   logic [7:0] pend_addr_reg;

   // software visible state
   logic [CTRL_W-1:0] ctrl_reg;
   logic [7:0] div_reg;
   logic [14:0] map_reg;
   logic [4:0] fmt_reg;
   logic [15:0] pat_reg;
   logic [SAMPLE_W-1:0] tx_reg [NUM_CH];
   logic ovr_reg;

   // link side state
   link_state_t state_reg;
   logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
   logic sync_s1_reg, sync_s2_reg, sync_prev_reg;
   logic din_s1_reg, din_s2_reg;
   logic [7:0] div_cnt_reg;
   logic bclk_reg;
   logic [7:0] bit_reg;
   logic start_pend_reg;
   logic [WORD_W-1:0] tx_lat_reg;
   logic [WORD_W-1:0] rx_sh_reg;
   logic [1:0] rx_ch_reg;
   logic rx_push_reg;
   logic [RX_W-1:0] rx_data_reg;

   // fifo handshake
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [RX_W-1:0] fifo_out_data;

   // address phase is taken only for active transfers; hsize is ignored
   // since only whole-word accesses are supported
   wire take = hsel & hready & htrans[1];
   wire wr = pend_reg & pend_write_reg;
   wire rd = pend_reg & ~pend_write_reg;
   wire wr_ctrl = wr & (pend_addr_reg == ADDR_CTRL);
   wire wr_div = wr & (pend_addr_reg == ADDR_DIV);
   wire wr_map = wr & (pend_addr_reg == ADDR_MAP);
   wire wr_fmt = wr & (pend_addr_reg == ADDR_FMT);
   wire wr_tx0 = wr & (pend_addr_reg == ADDR_TX0);
   wire wr_tx1 = wr & (pend_addr_reg == ADDR_TX1);
   wire wr_tx2 = wr & (pend_addr_reg == ADDR_TX2);
   wire wr_stat = wr & (pend_addr_reg == ADDR_STAT);
   wire rd_rx = rd & (pend_addr_reg == ADDR_RX);

   // control field decode
   wire en = ctrl_reg[CTRL_EN];
   wire master = ctrl_reg[CTRL_MASTER];
   wire long_sync = ctrl_reg[CTRL_LONG];
   wire [2:0] rate_raw = ctrl_reg[CTRL_RATE_LSB +: 3];
   wire [2:0] rate = (rate_raw > RATE_MAX) ? RATE_MAX : rate_raw;
   wire [1:0] pos = fmt_reg[FMT_POS_LSB +: 2];
   wire lsbf = fmt_reg[FMT_LSBF];
   wire [1:0] fill_mode = fmt_reg[FMT_FILL_LSB +: 2];

   // highest slot number and last bit of the frame for the chosen rate
   wire [4:0] slot_span = 5'h01 << rate;
   wire [3:0] slot_hi = 4'(slot_span - 5'h01);
   wire [7:0] frame_last = {slot_hi, BIT_LAST};

   // bit clock edges: own divider as master, synchronised pin as slave
   wire div_hit = (div_cnt_reg == div_reg);
   wire m_rise = master & div_hit & ~bclk_reg;
   wire m_fall = master & div_hit & bclk_reg;
   wire s_rise = ~master & clk_s2_reg & ~clk_s3_reg;
   wire s_fall = ~master & ~clk_s2_reg & clk_s3_reg;
   wire rise = en & (m_rise | s_rise);
   wire fall = en & (m_fall | s_fall);
   wire run = (state_reg == ST_RUN);

   // next bit position taken at the coming rising edge
   wire bit_wrap = (bit_reg == frame_last);
   wire [7:0] bit_nx = (start_pend_reg | bit_wrap) ? 8'h00 : bit_reg + 8'h01;
   wire [3:0] slot_nx = bit_nx[7:4];
   wire [3:0] idx_nx = bit_nx[3:0];
   wire [3:0] slot_now = bit_reg[7:4];
   wire [3:0] idx_now = bit_reg[3:0];

   // slot ownership, one comparator pair per channel
   logic [NUM_CH-1:0] tx_hit;
   logic [NUM_CH-1:0] rx_hit;
   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++)
      begin : g_ch
         wire ch_en = map_reg[MAP_EN_LSB + c];
         wire [3:0] ch_slot = map_reg[4*c +: 4];
         assign tx_hit[c] = ch_en & (ch_slot == slot_nx)
            & (slot_nx <= slot_hi);
         assign rx_hit[c] = ch_en & (ch_slot == slot_now)
            & (slot_now <= slot_hi);
      end
   endgenerate

   // lowest channel wins if software maps two onto one slot
   wire tx_own = |tx_hit;
   wire rx_own = |rx_hit;
   wire [1:0] tx_ch = tx_hit[0] ? 2'd0 : (tx_hit[1] ? 2'd1 : 2'd2);
   wire [1:0] rx_ch = rx_hit[0] ? 2'd0 : (rx_hit[1] ? 2'd1 : 2'd2);

   // transmit word: sample placed at pos, spare bits from the fill source
   wire [SAMPLE_W-1:0] tx_smp = tx_reg[tx_ch];
   wire [WORD_W-1:0] smp_mask = SAMPLE_MASK << pos;
   wire [WORD_W-1:0] smp_wide = {3'h0, tx_smp};
   wire [WORD_W-1:0] smp_placed = smp_wide << pos;
   wire [WORD_W-1:0] fill_src = (fill_mode == FILL_ZERO) ? 16'h0000 :
      (fill_mode == FILL_ONE) ? 16'hFFFF :
      (fill_mode == FILL_SIGN) ? {WORD_W{tx_smp[SAMPLE_W-1]}} :
      pat_reg;
   wire [WORD_W-1:0] tx_word = smp_placed | (fill_src & ~smp_mask);

   // word is captured at bit 0 so a mid-slot write cannot tear it
   wire [WORD_W-1:0] tx_cur = (idx_nx == 4'h0) ? tx_word : tx_lat_reg;
   wire [3:0] tx_sel = lsbf ? idx_nx : BIT_LAST - idx_nx;
   wire tx_bit = tx_cur[tx_sel];

   // receive shifter; spare bits are simply dropped on extraction
   wire [WORD_W-1:0] rx_sh_nx = lsbf ? {din_s2_reg, rx_sh_reg[WORD_W-1:1]}
      : {rx_sh_reg[WORD_W-2:0], din_s2_reg};
   wire [WORD_W-1:0] rx_shifted = rx_sh_nx >> pos;
   wire [SAMPLE_W-1:0] rx_smp = rx_shifted[SAMPLE_W-1:0];

   // master sync level for the bit about to start
   wire sync_short = (bit_nx == frame_last);
   wire sync_long = (bit_nx <= LONG_SYNC_LAST);
   wire sync_lvl = long_sync ? sync_long : sync_short;
   wire sync_edge = sync_s2_reg & ~sync_prev_reg;

   // bus answer mux, reserved bits read as zero
   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (pend_addr_reg)
         ADDR_CTRL: rd_val[CTRL_W-1:0] = ctrl_reg;
         ADDR_DIV: rd_val[7:0] = div_reg;
         ADDR_MAP: rd_val[14:0] = map_reg;
         ADDR_FMT:
         begin
            rd_val[4:0] = fmt_reg;
            rd_val[FMT_PAT_LSB +: WORD_W] = pat_reg;
         end
         ADDR_TX0: rd_val[SAMPLE_W-1:0] = tx_reg[0];
         ADDR_TX1: rd_val[SAMPLE_W-1:0] = tx_reg[1];
         ADDR_TX2: rd_val[SAMPLE_W-1:0] = tx_reg[2];
         ADDR_RX:
         begin
            rd_val[SAMPLE_W-1:0] = fifo_out_data[SAMPLE_W-1:0];
            rd_val[RX_CH_LSB +: 2] = fifo_out_data[RX_W-1:SAMPLE_W];
            rd_val[RX_VALID] = fifo_out_valid;
         end
         ADDR_STAT:
         begin
            rd_val[STAT_LOCK] = run;
            rd_val[STAT_OVR] = ovr_reg;
            rd_val[STAT_RXV] = fifo_out_valid;
            rd_val[STAT_SLOT_LSB +: 4] = slot_now;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // one wait state per transfer keeps hrdata a plain register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_reg <= 1'b0;
         pend_write_reg <= 1'b0;
         pend_addr_reg <= 8'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= RESP_OKAY;
      end
      else
      begin
         hresp <= RESP_OKAY;
         if (take)
         begin
            pend_reg <= 1'b1;
            pend_write_reg <= hwrite;
            pend_addr_reg <= haddr[7:0];
            hreadyout <= 1'b0;
         end
         else if (pend_reg)
         begin
            pend_reg <= 1'b0;
            hreadyout <= 1'b1;
            if (rd)
               hrdata <= rd_val;
         end
      end
   end

   // configuration registers; reset gives the default sample format
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg <= CTRL_RST;
         div_reg <= DIV_RST;
         map_reg <= MAP_RST;
         fmt_reg <= FMT_RST;
         pat_reg <= PAT_RST;
         tx_reg[0] <= '0;
         tx_reg[1] <= '0;
         tx_reg[2] <= '0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_reg <= hwdata[CTRL_W-1:0];
         if (wr_div)
            div_reg <= hwdata[7:0];
         if (wr_map)
            map_reg <= hwdata[14:0];
         if (wr_fmt)
         begin
            fmt_reg <= hwdata[4:0];
            pat_reg <= hwdata[FMT_PAT_LSB +: WORD_W];
         end
         if (wr_tx0)
            tx_reg[0] <= hwdata[SAMPLE_W-1:0];
         if (wr_tx1)
            tx_reg[1] <= hwdata[SAMPLE_W-1:0];
         if (wr_tx2)
            tx_reg[2] <= hwdata[SAMPLE_W-1:0];
      end
   end

   // overrun is sticky, write one clears; a new overrun wins the clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ovr_reg <= 1'b0;
      else if (rx_push_reg && !fifo_in_ready)
         ovr_reg <= 1'b1;
      else if (wr_stat && hwdata[STAT_OVR])
         ovr_reg <= 1'b0;
   end

   // pins from the far side pass two flops before any logic sees them
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_s1_reg <= 1'b0;
         clk_s2_reg <= 1'b0;
         clk_s3_reg <= 1'b0;
         sync_s1_reg <= 1'b0;
         sync_s2_reg <= 1'b0;
         din_s1_reg <= 1'b0;
         din_s2_reg <= 1'b0;
      end
      else
      begin
         clk_s1_reg <= pcm_clk_i;
         clk_s2_reg <= clk_s1_reg;
         clk_s3_reg <= clk_s2_reg;
         sync_s1_reg <= pcm_sync_i;
         sync_s2_reg <= sync_s1_reg;
         din_s1_reg <= pcm_din;
         din_s2_reg <= din_s1_reg;
      end
   end

   // master bit clock divider; also drives the clock and sync enables
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_cnt_reg <= 8'h00;
         bclk_reg <= 1'b0;
         pcm_clk_o <= 1'b0;
         pcm_clk_oe <= 1'b0;
         pcm_sync_oe <= 1'b0;
      end
      else
      begin
         pcm_clk_oe <= en & master;
         pcm_sync_oe <= en & master;
         // pin follows the divider on the same edge, so data and sync
         // launched at a rise never lead the clock pin
         if (!(en && master))
         begin
            div_cnt_reg <= 8'h00;
            bclk_reg <= 1'b0;
            pcm_clk_o <= 1'b0;
         end
         else if (div_hit)
         begin
            div_cnt_reg <= 8'h00;
            bclk_reg <= ~bclk_reg;
            pcm_clk_o <= ~bclk_reg;
         end
         else
            div_cnt_reg <= div_cnt_reg + 8'h01;
      end
   end

   // frame tracking: master runs at once, slave hunts for sync
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= ST_OFF;
         bit_reg <= BIT_IDLE;
         start_pend_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_OFF:
            begin
               bit_reg <= BIT_IDLE;
               start_pend_reg <= 1'b0;
               if (en)
                  state_reg <= master ? ST_RUN : ST_HUNT;
            end
            ST_HUNT, ST_RUN:
            begin
               if (!en)
                  state_reg <= ST_OFF;
               else
               begin
                  if (rise)
                  begin
                     if (master || state_reg == ST_RUN || start_pend_reg)
                        bit_reg <= bit_nx;
                     if (start_pend_reg)
                        state_reg <= ST_RUN;
                     start_pend_reg <= 1'b0;
                  end
                  if (fall && !master)
                  begin
                     sync_prev_reg <= sync_s2_reg;
                     if (!long_sync && sync_s2_reg)
                        start_pend_reg <= 1'b1;
                     if (long_sync && sync_edge)
                     begin
                        bit_reg <= 8'h00;
                        state_reg <= ST_RUN;
                     end
                  end
               end
            end
            default: state_reg <= ST_OFF;
         endcase
      end
   end

   // transmit side: launch on rising, release after last falling edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pcm_dout <= 1'b0;
         pcm_dout_oe <= 1'b0;
         pcm_sync_o <= 1'b0;
         tx_lat_reg <= '0;
      end
      else if (!en)
      begin
         pcm_dout_oe <= 1'b0;
         pcm_sync_o <= 1'b0;
      end
      else
      begin
         if (rise)
         begin
            pcm_sync_o <= master & sync_lvl;
            // lock rise of a slave counts as running, else bit 0 is lost
            if ((run || start_pend_reg) && tx_own)
            begin
               pcm_dout <= tx_bit;
               pcm_dout_oe <= 1'b1;
               if (idx_nx == 4'h0)
                  tx_lat_reg <= tx_word;
            end
            else
               pcm_dout_oe <= 1'b0;
         end
         else if (fall && idx_now == BIT_LAST)
            pcm_dout_oe <= 1'b0;
      end
   end

   // receive side: sample on falling edge, push one word per owned slot
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_sh_reg <= '0;
         rx_ch_reg <= 2'd0;
         rx_push_reg <= 1'b0;
         rx_data_reg <= '0;
      end
      else
      begin
         rx_push_reg <= 1'b0;
         if (en && run && fall && rx_own)
         begin
            rx_sh_reg <= rx_sh_nx;
            rx_ch_reg <= rx_ch;
            if (idx_now == BIT_LAST)
            begin
               rx_push_reg <= 1'b1;
               rx_data_reg <= {rx_ch, rx_smp};
            end
         end
      end
   end

   // a full fifo drops the word and raises overrun instead of stalling
   voice_fifo #(
      .WIDTH(RX_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(hclk),
      .rst_n(hresetn),
      .in_valid(rx_push_reg),
      .in_ready(fifo_in_ready),
      .in_data(rx_data_reg),
      .out_valid(fifo_out_valid),
      .out_ready(rd_rx),
      .out_data(fifo_out_data)
   );

endmodule

// ==== hdl/voice_fifo.sv ====
`timescale 1ns/1ps
module voice_fifo
#(
   parameter int WIDTH = 15,
   parameter int DEPTH = 4
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] count_reg;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // honest flags straight from the occupancy count
   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rptr_reg];

   // storage has no reset; only pointers and count need a known value
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_reg[wptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
            wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
         if (pop)
            rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule
